// *** dv/csap_monitor.sv ***
`timescale 1ns/1ps
// Link checks between the two ends
module csap_monitor (
  input wire logic ref_clk_in,
  input wire logic srst_in,
  input wire logic [7:0] completion_keep,
  input wire logic [32:0] completion_sideband,
  input wire logic completion_valid,
  input wire logic completion_last,
  input wire logic completion_ready
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (srst_in);
  // Offered but refused: the beat must stand
  sequence stall;
    completion_valid && !completion_ready;
  endsequence
  a_abort_valid: assert property (completion_sideband[0] |-> completion_valid)
    else $error("abort alone");
  a_hold_valid: assert property (stall |=> completion_valid) else $error("drop");
  a_hold_keep: assert property (stall |=> $stable(completion_keep)) else $error("keep");
  a_hold_side: assert property (stall |=> $stable(completion_sideband))
    else $error("side");
  a_hold_last: assert property (stall |=> $stable(completion_last)) else $error("last");
  a_abort_ends: assert property (completion_sideband[0] |-> completion_last)
    else $error("abort");
  a_mid_keep: assert property (completion_valid & !completion_last |-> &completion_keep)
    else $error("partial");
  a_keep_first: assert property (completion_valid |-> completion_keep[0])
    else $error("empty");
endmodule // csap_monitor

// *** dv/tb.sv ***
`timescale 1ns/1ps
`define CK(a, b) begin n_checks++; if ((a) !== (b)) begin n_fail++; \
  $display("BAD %0t %h %h", $time, a, b); end end
module tb;
  localparam logic [255:0] D1 = {8{32'h01a2_b3c4}};
  logic clk = 0, rst = 1, pe = 1, ep = 1, tr = 0, uv = 0, ul = 0, ua = 0, ur, tv, tn, ta, te;
  logic cpe = 1, tl;
  logic [7:0] uk = 8'hff, tk, lk;
  logic [255:0] ud = '0, td, ld;
  int n_fail = 0, n_checks = 0, cyc = 0, k[5];
  csap_if i_csap_if ();
  csap_client i_csap_client (.ref_clk_in(clk), .srst_in(rst), .clk_en_in(1'b1), .par_en_in(cpe),
    .user_valid_in(uv), .user_data_in(ud), .user_keep_in(uk), .user_last_in(ul),
    .user_abort_in(ua), .user_ready_out(ur), .link(i_csap_if));
  csap_device i_csap_device (.ref_clk_in(clk), .srst_in(rst), .clk_en_in(1'b1), .par_en_in(pe),
    .is_endpoint_in(ep), .tx_ready_in(tr), .tx_valid_out(tv), .tx_data_out(td), .tx_keep_out(tk),
    .tx_last_out(tl), .tx_nullify_out(tn), .aer_abort_out(ta), .internal_err_out(te),
    .link(i_csap_if));
  csap_monitor i_csap_monitor (.ref_clk_in(clk), .srst_in(rst),
    .completion_keep(i_csap_if.completion_keep),
    .completion_sideband(i_csap_if.completion_sideband),
    .completion_valid(i_csap_if.completion_valid), .completion_last(i_csap_if.completion_last),
    .completion_ready(i_csap_if.completion_ready));
  initial forever #2.5 clk = ~clk;
  // Far side stalls one cycle in three to push back on the link
  always @(posedge clk) begin
    cyc <= cyc + 1;
    tr <= cyc % 3 != 0;
  end
  // Tally mid-cycle, once outputs have settled
  always @(negedge clk) begin
    if (tv && tr) begin
      k[0]++;
      k[1] += tn;
      k[4] += tl;
      ld = td;
      lk = tk;
    end
    k[2] += ta;
    k[3] += te;
  end
  task automatic put(input logic [255:0] d, input logic l, a);
    // Beats put with last carry a partial keep, all others (aborting ones too) a full one
    {uv, ud, ul, ua, uk} <= {1'b1, d, l, a, (l ? 8'h0f : 8'hff)};
    do @(posedge clk); while (ur !== 1'b1);
  endtask
  task automatic idle(input int t);
    {uv, ua} <= 2'h0;
    repeat (10) @(posedge clk);
    $display("test %0d done", t);
  endtask
  task automatic finish_test;
    $display("checks %0d fails %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Tests need about a hundred cycles; this is far beyond
  initial begin
    #20000;
    n_fail++;
    finish_test;
  end
  initial begin
    repeat (20) @(posedge clk);
    rst <= 0;
    k = '{default: 0};
    put(D1, 0, 0);
    put(~D1, 1, 0);
    idle(1);
    `CK(k[0], 2)
    `CK(k[1] + k[3], 0)
    `CK(ld, ~D1)
    `CK(k[4], 1)
    `CK(lk, 8'h0f)
    k = '{default: 0};
    put(D1, 0, 0);
    put(~D1, 0, 1);
    idle(2);
    `CK(k[1], 1)
    `CK(k[2], 1)
    `CK(k[4], 1)
    // Client parity off, checking on: zero bytes fail, odd-weight bytes pass
    k = '{default: 0};
    cpe <= 1'b0;
    put('0, 0, 0);
    put(D1, 1, 0);
    put(D1, 1, 0);
    idle(3);
    `CK(k[0], 3)
    `CK(k[1], 2)
    `CK(k[3], 1)
    `CK(k[2], 0)
    k = '{default: 0};
    {ep, pe} <= 2'h0;
    put('0, 1, 1);
    idle(4);
    `CK(k[1], 1)
    `CK(k[2], 0)
    `CK(k[3], 0)
    finish_test;
  end
endmodule // tb

// *** src/csap_client.sv ***
`timescale 1ns/1ps
// Client end: buffers one beat from its user and drives the stream.
// Parity and abort are generated here; the user only flags bad data.
module csap_client
  import csap_pkg::*;
#(
  parameter int DATA_WIDTH = csap_pkg::CSAP_DATA_WIDTH_DEF
) (
  input wire logic ref_clk_in,
  input wire logic srst_in,
  input wire logic clk_en_in,
  input wire logic par_en_in,
  input wire logic user_valid_in,
  input wire logic [DATA_WIDTH-1:0] user_data_in,
  input wire logic [DATA_WIDTH/32-1:0] user_keep_in,
  input wire logic user_last_in,
  input wire logic user_abort_in,
  output logic user_ready_out,
  csap_if.client link
);
  localparam int NBYTES = DATA_WIDTH / CSAP_BYTE_BITS;

  logic busy_ff;
  logic [DATA_WIDTH-1:0] data_ff;
  logic [DATA_WIDTH/32-1:0] keep_ff;
  logic last_ff;
  logic abort_ff;
  logic [CSAP_PAR_WIDTH-1:0] par_ff;
  logic [CSAP_PAR_WIDTH-1:0] nxt_par;
  logic take;

  // One-beat holding slot keeps data stable while ready is low
  assign user_ready_out = clk_en_in && (!busy_ff || link.completion_ready);
  assign take = user_ready_out && user_valid_in;

  // Odd parity per byte; unused upper bits tied low for narrow paths
  for (genvar i = 0; i < NBYTES; i++) begin : g_par
    assign nxt_par[i] = par_en_in & ~(^user_data_in[i*8 +: 8]);
  end
  if (NBYTES < CSAP_PAR_WIDTH) begin : g_par_pad
    assign nxt_par[CSAP_PAR_WIDTH-1:NBYTES] = '0;
  end

  // Slot occupancy
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      busy_ff <= CSAP_RST_INPKT;
    end else if (clk_en_in) begin
      if (take) begin
        busy_ff <= 1'b1;
      end else if (link.completion_ready) begin
        busy_ff <= 1'b0;
      end
    end
  end

  // Beat contents change only on a fresh take, so a stalled beat holds
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      data_ff <= '0;
      keep_ff <= '0;
      last_ff <= 1'b0;
      abort_ff <= 1'b0;
      par_ff <= '0;
    end else if (clk_en_in && take) begin
      data_ff <= user_data_in;
      keep_ff <= user_keep_in;
      last_ff <= user_last_in | user_abort_in;
      abort_ff <= user_abort_in;
      par_ff <= nxt_par;
    end
  end

  assign link.completion_valid = busy_ff;
  assign link.completion_data = data_ff;
  assign link.completion_keep = keep_ff;
  assign link.completion_last = last_ff;
  // Abort only qualified by valid
  assign link.completion_sideband = {par_ff, abort_ff & busy_ff};
endmodule // csap_client

// *** src/csap_device.sv ***
`timescale 1ns/1ps
// How it works
// - Client may abort in any packet beat.
// - Aborted packet is nullified on the link.
// - Client may end early or finish payload.
// - Abort stays sticky for remaining beats.
// - Abort only raised with valid.
// - Abort sampled only while ready high.
// - Endpoint reports abort through error reporting.
// - Parity bit i is odd parity of byte i.
// - Narrow paths use only low parity bits.
// - Parity mismatch nullifies and reports internal error.
// - Parity may be tied low when disabled.
// - Beat moves when valid and ready; hold stable.
// - Last marks final beat, even single-beat packets.
// - Keep contiguous; only final beat partial.
module csap_device
  import csap_pkg::*;
#(
  parameter int DATA_WIDTH = csap_pkg::CSAP_DATA_WIDTH_DEF
) (
  input wire logic ref_clk_in,
  input wire logic srst_in,
  input wire logic clk_en_in,
  input wire logic par_en_in,
  input wire logic is_endpoint_in,
  input wire logic tx_ready_in,
  output logic tx_valid_out,
  output logic [DATA_WIDTH-1:0] tx_data_out,
  output logic [DATA_WIDTH/32-1:0] tx_keep_out,
  output logic tx_last_out,
  output logic tx_nullify_out,
  output logic aer_abort_out,
  output logic internal_err_out,
  csap_if.device link
);
  localparam int NBYTES = DATA_WIDTH / CSAP_BYTE_BITS;

  // Packet error state: clean, errored by parity, or aborted by the client
  typedef enum logic [1:0] {
    PKT_CLEAN,
    PKT_ERRORED,
    PKT_ABORTED
  } csap_pkt_e;

  logic beat;
  logic last_beat;
  logic drain;
  logic abort_now;
  logic par_bad;
  logic [NBYTES-1:0] byte_bad;
  logic pkt_err;
  csap_pkt_e pkt_state_ff;
  csap_pkt_e nxt_pkt_state;
  logic out_busy_ff;
  logic [DATA_WIDTH-1:0] tx_data_ff;
  logic [DATA_WIDTH/32-1:0] tx_keep_ff;
  logic tx_last_ff;
  logic tx_nullify_ff;
  logic aer_abort_ff;
  logic internal_err_ff;

  // One output stage; ready follows its drain so the client is stalled honestly
  assign link.completion_ready = clk_en_in && (!out_busy_ff || tx_ready_in);
  assign beat = link.completion_valid && link.completion_ready;
  assign last_beat = beat && link.completion_last;
  // The held beat leaves when the far side takes it
  assign drain = out_busy_ff && tx_ready_in;

  // Abort is looked at only on accepted beats, never while stalled
  assign abort_now = beat && link.completion_sideband[CSAP_SB_ABORT_BIT];

  // Per-byte odd parity compare; only bytes of the configured width take part
  for (genvar i = 0; i < NBYTES; i++) begin : g_par
    logic [CSAP_BYTE_BITS-1:0] byte_val;
    logic par_bit;
    assign byte_val = link.completion_data[i*CSAP_BYTE_BITS +: CSAP_BYTE_BITS];
    assign par_bit = link.completion_sideband[CSAP_SB_PAR_LSB + i];
    // Byte and its parity bit together must hold an odd count of ones
    assign byte_bad[i] = ~(^{byte_val, par_bit});
  end
  // Tied-low parity bits are harmless while checking is off
  assign par_bad = beat && par_en_in && (|byte_bad);

  // Errored if this beat or an earlier beat of the same packet was
  assign pkt_err = (pkt_state_ff != PKT_CLEAN) || abort_now || par_bad;

  // Next packet state; every last beat returns to clean for the next packet
  // Abort is kept apart from parity so that its report is never swallowed
  always_comb begin
    nxt_pkt_state = pkt_state_ff;
    case (pkt_state_ff)
      PKT_CLEAN: begin
        if (last_beat) begin
          nxt_pkt_state = PKT_CLEAN;
        end else if (abort_now) begin
          nxt_pkt_state = PKT_ABORTED;
        end else if (par_bad) begin
          nxt_pkt_state = PKT_ERRORED;
        end
      end
      PKT_ERRORED: begin
        // A later abort must still be reported, so it moves on
        if (last_beat) begin
          nxt_pkt_state = PKT_CLEAN;
        end else if (abort_now) begin
          nxt_pkt_state = PKT_ABORTED;
        end
      end
      PKT_ABORTED: begin
        if (last_beat) begin
          nxt_pkt_state = PKT_CLEAN;
        end
      end
      default: begin
        nxt_pkt_state = PKT_CLEAN;
      end
    endcase
  end

  // Packet state register
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      pkt_state_ff <= PKT_CLEAN;
    end else if (clk_en_in) begin
      pkt_state_ff <= nxt_pkt_state;
    end
  end

  // Output stage occupancy: filled by a beat, emptied by a drain
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      out_busy_ff <= CSAP_RST_INPKT;
    end else if (clk_en_in) begin
      if (beat) begin
        out_busy_ff <= 1'b1;
      end else if (drain) begin
        out_busy_ff <= 1'b0;
      end
    end
  end

  // Data loads only on a beat, so a stalled output holds
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      tx_data_ff <= '0;
    end else if (clk_en_in && beat) begin
      tx_data_ff <= link.completion_data;
    end
  end

  // Keep pattern passes through untouched
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      tx_keep_ff <= '0;
    end else if (clk_en_in && beat) begin
      tx_keep_ff <= link.completion_keep;
    end
  end

  // End of packet, early when the client aborts
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      tx_last_ff <= 1'b0;
    end else if (clk_en_in && beat) begin
      tx_last_ff <= link.completion_last;
    end
  end

  // Nullify marks every errored beat of the TLP
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      tx_nullify_ff <= CSAP_RST_ERR;
    end else if (clk_en_in && beat) begin
      tx_nullify_ff <= pkt_err;
    end
  end

  // Abort report, endpoint only: one pulse per packet on its first aborting beat
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      aer_abort_ff <= 1'b0;
    end else if (clk_en_in) begin
      aer_abort_ff <= abort_now && (pkt_state_ff != PKT_ABORTED) && is_endpoint_in;
    end
  end

  // Internal error: one pulse per beat that fails parity
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      internal_err_ff <= 1'b0;
    end else if (clk_en_in) begin
      internal_err_ff <= par_bad;
    end
  end

  // Registered outputs toward the link
  assign tx_valid_out = out_busy_ff;
  assign tx_data_out = tx_data_ff;
  assign tx_keep_out = tx_keep_ff;
  assign tx_last_out = tx_last_ff;
  assign tx_nullify_out = tx_nullify_ff;

  // Registered error reports
  assign aer_abort_out = aer_abort_ff;
  assign internal_err_out = internal_err_ff;
endmodule // csap_device

// *** src/csap_if.sv ***
`timescale 1ns/1ps
interface csap_if #(
  parameter int DATA_WIDTH = csap_pkg::CSAP_DATA_WIDTH_DEF
);
  logic [DATA_WIDTH-1:0] completion_data;
  logic [DATA_WIDTH/32-1:0] completion_keep;
  logic [csap_pkg::CSAP_SB_WIDTH-1:0] completion_sideband;
  logic completion_valid;
  logic completion_last;
  logic completion_ready;

  // Device end takes the stream, client end sources it
  modport device (
    input completion_data, completion_keep, completion_sideband,
    input completion_valid, completion_last,
    output completion_ready
  );
  modport client (
    output completion_data, completion_keep, completion_sideband,
    output completion_valid, completion_last,
    input completion_ready
  );
endinterface

// *** src/csap_pkg.sv ***
package csap_pkg;
  // Sideband layout
  localparam int CSAP_SB_WIDTH = 33;
  localparam int CSAP_SB_ABORT_BIT = 0;
  localparam int CSAP_SB_PAR_LSB = 1;
  localparam int CSAP_PAR_WIDTH = 32;
  // Data path widths
  localparam int CSAP_DATA_WIDTH_MAX = 256;
  localparam int CSAP_DATA_WIDTH_DEF = 256;
  localparam int CSAP_DWORD_BITS = 32;
  localparam int CSAP_BYTE_BITS = 8;
  // Reset values
  localparam logic CSAP_RST_ERR = 1'b0;
  localparam logic CSAP_RST_INPKT = 1'b0;
  localparam logic [7:0] CSAP_RST_CNT = 8'h00;
endpackage
